//--- fmcr_pkg.sv
// package for the flash mode control register block
// assumes a 32-bit avalon-mm slave with word addressing by byte address
package fmcr_pkg;

  // ==========================================================
  // register map
  localparam logic [3:0] MODE_CTRL_OFFSET = 4'h0; // flash_mode_control_1
  localparam logic [3:0] STATUS_OFFSET    = 4'h4; // status word holding the decoded operating mode
  localparam logic [7:0] MODE_RESET_VALUE = 8'h80;
  localparam logic [7:0] DISABLED_READ    = 8'h00;

  // ==========================================================
  // bit positions of the mode control register
  localparam int unsigned BIT_HW_GUARD  = 7;
  localparam int unsigned BIT_SW_WE     = 6;
  localparam int unsigned BIT_ERASE_SU  = 5;
  localparam int unsigned BIT_PROG_SU   = 4;
  localparam int unsigned BIT_ERASE_VER = 3;
  localparam int unsigned BIT_PROG_VER  = 2;
  localparam int unsigned BIT_ERASE_RUN = 1;
  localparam int unsigned BIT_PROG_RUN  = 0;

  // ==========================================================
  // mode bits as a packed struct, bit 7 first
  typedef struct packed {
    logic hw_write_guard;
    logic sw_write_enable;
    logic erase_setup;
    logic program_setup;
    logic erase_verify;
    logic program_verify;
    logic erase_run;
    logic program_run;
  } fmcr_mode_t;

  // operating mode as seen by the flash array
  typedef enum logic [2:0] {
    FMCR_IDLE,
    FMCR_PROG_VERIFY,
    FMCR_ERASE_VERIFY,
    FMCR_PROGRAM,
    FMCR_ERASE
  } fmcr_op_t;

endpackage

//--- fmcr_top.sv
// flash mode control register with gated write order
// assumes one 50 mhz clock, synchronous active-high reset, avalon-mm master
// assumes flash enable and both standby inputs are synchronous levels
// assumes the master holds each request until waitrequest is seen low
// the flash array timing and the block select registers live elsewhere
//
// What this block does, and what software must do (R11, R13, R14)
// R1: the mode register is eight bits, guard at bit 7 down to program run.
// R2: verify modes are entered only after sw write enable is set first.
// R3: program mode needs sw write enable, then program setup, then run.
// R4: erase mode needs sw write enable, then erase setup, then run.
// R5: reset and either standby mode load the register with 8'h80.
// R6: with flash disabled mode register reads return zero and writes are dropped.
// R7: setup and verify bits change only while sw write enable is one.
// R8: erase run changes only while sw write enable and erase setup are one.
// R9: program run changes only while sw write enable and program setup are 1.
// R10: the guard bit is read-only and reads one whenever flash is enabled.
// R11: software should set sw write enable before touching mode or blocks.
// R12: with sw write enable set, array reads pass only in a verify mode.
// R13: software must not set erase setup together with other mode bits.
// R14: software must not set program setup together with other mode bits.
//
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module fmcr_top #(
  parameter int unsigned MODE_WIDTH = 8 // width of the mode register
) (
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        flash_enable_i,
  input  wire logic        hw_standby_i,
  input  wire logic        sw_standby_i,
  output logic [7:0]       mode_o,
  output logic [2:0]       op_mode_o,
  output logic             array_read_ok_o
);

  // ==========================================================
  // elaboration checks
  // the bit map and the struct are fixed at eight bits
  if (MODE_WIDTH != 8) begin : g_width_check
    $error("mode register width must be eight");
  end

  // ==========================================================
  // state
  fmcr_pkg::fmcr_mode_t mode_q;
  fmcr_pkg::fmcr_mode_t mode_d;
  logic                 ack_q;
  logic                 wr_acc;
  logic                 rd_acc;
  fmcr_pkg::fmcr_op_t   op_d;

  // one wait cycle: accept on the second cycle of a request
  assign wr_acc = avs_write_i && ack_q;
  assign rd_acc = avs_read_i && ack_q;

  // ==========================================================
  // helpers
  // true when the decoded mode lets the array be read back
  function automatic logic is_verify(input fmcr_pkg::fmcr_op_t op);
    return op == fmcr_pkg::FMCR_PROG_VERIFY
           || op == fmcr_pkg::FMCR_ERASE_VERIFY;
  endfunction

  // gated write of the mode bits
  // gating looks at the value before the write, so one write can
  // never open a gate and pass through it in the same cycle
  function automatic fmcr_pkg::fmcr_mode_t gate_write(
    input fmcr_pkg::fmcr_mode_t cur,
    input logic [7:0]           wd
  );
    fmcr_pkg::fmcr_mode_t nx;
    nx = cur;
    nx.hw_write_guard  = 1'b1; // R10
    nx.sw_write_enable = wd[fmcr_pkg::BIT_SW_WE];
    if (cur.sw_write_enable) begin // R7 R2
      nx.erase_setup    = wd[fmcr_pkg::BIT_ERASE_SU];
      nx.program_setup  = wd[fmcr_pkg::BIT_PROG_SU];
      nx.erase_verify   = wd[fmcr_pkg::BIT_ERASE_VER];
      nx.program_verify = wd[fmcr_pkg::BIT_PROG_VER];
    end
    if (cur.sw_write_enable && cur.erase_setup) begin // R8 R4
      nx.erase_run = wd[fmcr_pkg::BIT_ERASE_RUN];
    end
    if (cur.sw_write_enable && cur.program_setup) begin // R9 R3
      nx.program_run = wd[fmcr_pkg::BIT_PROG_RUN];
    end
    return nx;
  endfunction

  // next value of the mode register
  always_comb begin
    mode_d = mode_q;
    if (wr_acc && flash_enable_i && avs_byteenable_i[0]
        && avs_address_i == fmcr_pkg::MODE_CTRL_OFFSET) begin // R6
      mode_d = gate_write(mode_q, avs_writedata_i[7:0]);
    end
  end

  // ==========================================================
  // mode register
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || hw_standby_i || sw_standby_i) begin // R5
      mode_q <= fmcr_pkg::MODE_RESET_VALUE; // R1
    end else begin
      mode_q <= mode_d;
    end
  end

  // ==========================================================
  // bus handshake: waitrequest high until the accept cycle
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_i || avs_write_i) && !ack_q;
    end
  end

  // waitrequest kept in its own flop, the inverse of the next accept
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack_q);
    end
  end

  // read data, registered only when a read is accepted next
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !ack_q) begin
      case (avs_address_i)
        fmcr_pkg::MODE_CTRL_OFFSET:
          avs_readdata_o <= {24'h00_0000, flash_enable_i ? mode_q
                             : fmcr_pkg::DISABLED_READ}; // R6
        fmcr_pkg::STATUS_OFFSET:
          avs_readdata_o <= {29'h0000_0000, op_d};
        default:
          avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // operating mode decode
  always_comb begin
    op_d = fmcr_pkg::FMCR_IDLE;
    if (mode_q.sw_write_enable) begin
      if (mode_q.program_setup && mode_q.program_run) begin // R3
        op_d = fmcr_pkg::FMCR_PROGRAM;
      end else if (mode_q.erase_setup && mode_q.erase_run) begin // R4
        op_d = fmcr_pkg::FMCR_ERASE;
      end else if (mode_q.program_verify) begin // R2
        op_d = fmcr_pkg::FMCR_PROG_VERIFY;
      end else if (mode_q.erase_verify) begin
        op_d = fmcr_pkg::FMCR_ERASE_VERIFY;
      end
    end
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      mode_o          <= fmcr_pkg::MODE_RESET_VALUE;
      op_mode_o       <= 3'h0;
      array_read_ok_o <= 1'b1;
    end else begin
      mode_o          <= mode_q;
      op_mode_o       <= op_d;
      array_read_ok_o <= !mode_q.sw_write_enable
                         || is_verify(op_d); // R12
    end
  end

  // ==========================================================
  // checks
  guard_high_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    mode_q.hw_write_guard) else $error("guard bit low"); // R10
  standby_load_a: assert property (@(posedge clk_sys_i)
    (hw_standby_i || sw_standby_i) |=> mode_q == 8'h80)
    else $error("standby did not load 80"); // R5
  setup_hold_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !mode_q.sw_write_enable && !hw_standby_i && !sw_standby_i
    |=> mode_q[5:2] == $past(mode_q[5:2])) else $error("setup changed"); // R7
  erase_run_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !(mode_q.sw_write_enable && mode_q.erase_setup) && !hw_standby_i
    && !sw_standby_i |=> mode_q.erase_run == $past(mode_q.erase_run))
    else $error("erase run changed"); // R8
  prog_run_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !(mode_q.sw_write_enable && mode_q.program_setup) && !hw_standby_i
    && !sw_standby_i |=> mode_q.program_run == $past(mode_q.program_run))
    else $error("program run changed"); // R9
  disabled_hold_a: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i || hw_standby_i || sw_standby_i)
    !flash_enable_i |=> $stable(mode_q)) else $error("write while off"); // R6
  array_gate_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    mode_q.sw_write_enable && !mode_q.program_verify && !mode_q.erase_verify
    |=> !array_read_ok_o) else $error("array read not blocked"); // R12
  program_order_a: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i)
    op_d == fmcr_pkg::FMCR_PROGRAM && $past(op_d) != fmcr_pkg::FMCR_PROGRAM
    |-> $past(mode_q.program_setup) && $past(mode_q.sw_write_enable))
    else $error("program entered out of order"); // R3
  erase_order_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    op_d == fmcr_pkg::FMCR_ERASE && $past(op_d) != fmcr_pkg::FMCR_ERASE
    |-> $past(mode_q.erase_setup) && $past(mode_q.sw_write_enable))
    else $error("erase entered out of order"); // R4
  verify_order_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(mode_q.program_verify) |-> $past(mode_q.sw_write_enable))
    else $error("verify without enable"); // R2

  // erase verify needs the enable one write earlier as well
  ev_order_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(mode_q.erase_verify)
    |-> $past(mode_q.sw_write_enable))
    else $error("erase verify without enable"); // R2

  // reset always leaves the register at its initial value
  reset_load_a: assert property (@(posedge clk_sys_i)
    sys_rst_i
    |=> mode_q == fmcr_pkg::MODE_RESET_VALUE)
    else $error("reset did not load 80"); // R5

  // waitrequest drops for exactly one cycle per transfer
  wait_pulse_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !avs_waitrequest_o
    |=> avs_waitrequest_o)
    else $error("waitrequest low too long"); // R1

  // a fresh request is answered after one wait cycle
  wait_answer_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (avs_read_i || avs_write_i) && !ack_q
    |=> !avs_waitrequest_o)
    else $error("request not answered"); // R1

  // the mode output is a one-cycle copy of the register
  mode_copy_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    1'b1
    |=> mode_o == $past(mode_q))
    else $error("mode output lags wrongly"); // R1

  // the operating mode output follows the decode by one cycle
  op_copy_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    1'b1
    |=> op_mode_o == $past(op_d))
    else $error("op mode output lags wrongly"); // R3

  // a read of the mode register while flash is off gives zero
  off_read_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    avs_read_i && !ack_q && !flash_enable_i
    && avs_address_i == fmcr_pkg::MODE_CTRL_OFFSET
    |=> avs_readdata_o == 32'h0000_0000)
    else $error("read while off not zero"); // R6

  // a verify mode always opens the array for reads
  verify_read_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    is_verify(op_d)
    |=> array_read_ok_o)
    else $error("verify read blocked"); // R12

endmodule

`default_nettype wire

//--- test_fmcr_top.sv
// testbench for the flash mode control register block
// assumes fmcr_top with an avalon-mm slave port and one 50 mhz clock
`timescale 1ns/1ps
`default_nettype none

module test_fmcr_top;
  logic        clk_sys_i;
  logic        sys_rst_i;
  logic        rd;
  logic        wr;
  logic        fen;
  logic        hsb;
  logic        ssb;
  logic [3:0]  adr;
  logic [3:0]  be;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] got;
  logic        wreq;
  logic        rok;
  logic [7:0]  mode;
  logic [2:0]  op;
  int          bad_count;
  int          n_tests;
  // write sequence with expected register, op mode and array read gate
  // after the first entry, enable comes first and setups go alone
  logic [7:0]  wv [12] = '{8'hff, 8'h00, 8'h41, 8'h42, 8'h50, 8'h51,
                           8'h40, 8'h44, 8'h48, 8'h60, 8'h62, 8'h00};
  logic [7:0]  ev [12] = '{8'hc0, 8'h80, 8'hc0, 8'hc0, 8'hd0, 8'hd1,
                           8'hc0, 8'hc4, 8'hc8, 8'he0, 8'he2, 8'h80};
  logic [2:0]  ov [12] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h3,
                           3'h0, 3'h1, 3'h2, 3'h0, 3'h4, 3'h0};
  logic        kv [12] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0,
                           1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

  fmcr_top fmcr_top_inst (
    .clk_sys_i        (clk_sys_i),
    .sys_rst_i        (sys_rst_i),
    .avs_address_i    (adr),
    .avs_read_i       (rd),
    .avs_write_i      (wr),
    .avs_writedata_i  (wdat),
    .avs_byteenable_i (be),
    .avs_readdata_o   (rdat),
    .avs_waitrequest_o(wreq),
    .flash_enable_i   (fen),
    .hw_standby_i     (hsb),
    .sw_standby_i     (ssb),
    .mode_o           (mode),
    .op_mode_o        (op),
    .array_read_ok_o  (rok)
  );

  // ==========================================================
  // clock, verdict, compare and bus tasks
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task automatic give_verdict;
    if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one avalon transfer, held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    int i;
    wr <= w;
    rd <= ~w;
    adr <= a;
    wdat <= {24'h0, d};
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys_i);
      if (wreq === 1'b0) break;
    end
    if (i == 20) begin
      bad_count++;
      give_verdict();
    end
    got = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    bad_count = 0;
    n_tests = 0;
    {rd, wr, hsb, ssb} = 4'h0;
    fen = 1'b1;
    be = 4'hf;
    adr = 4'h0;
    wdat = 32'h0;
    sys_rst_i = 1'b1;
    repeat (5) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    acc(1'b0, 4'h0, 8'h00);
    chk("reset value", 32'h80, got);
    chk("reset mode_o", 32'h80, {24'h0, mode});
    // gated write order, every mode entered in turn
    for (int k = 0; k < 12; k++) begin
      acc(1'b1, 4'h0, wv[k]);
      acc(1'b0, 4'h0, 8'h00);
      repeat (2) @(posedge clk_sys_i);
      chk("readback", {24'h0, ev[k]}, got);
      chk("mode_o", {24'h0, ev[k]}, {24'h0, mode});
      chk("op_mode", {29'h0, ov[k]}, {29'h0, op});
      chk("array_ok", {31'h0, kv[k]}, {31'h0, rok});
      acc(1'b0, 4'h4, 8'h00);
      chk("status", {29'h0, ov[k]}, got);
    end
    // low byte lane disabled drops the write
    be <= 4'he;
    acc(1'b1, 4'h0, 8'h40);
    be <= 4'hf;
    acc(1'b0, 4'h0, 8'h00);
    chk("lane off", 32'h80, got);
    // each standby input reloads the register
    for (int s = 0; s < 2; s++) begin
      acc(1'b1, 4'h0, 8'h40);
      hsb <= (s == 0);
      ssb <= (s == 1);
      repeat (2) @(posedge clk_sys_i);
      hsb <= 1'b0;
      ssb <= 1'b0;
      @(posedge clk_sys_i);
      acc(1'b0, 4'h0, 8'h00);
      chk("standby", 32'h80, got);
    end
    // flash disabled: reads zero, writes dropped
    fen <= 1'b0;
    acc(1'b0, 4'h0, 8'h00);
    chk("disabled read", 32'h0, got);
    acc(1'b1, 4'h0, 8'h40);
    fen <= 1'b1;
    acc(1'b0, 4'h0, 8'h00);
    chk("disabled write", 32'h80, got);
    acc(1'b0, 4'h8, 8'h00);
    chk("unmapped", 32'h0, got);
    give_verdict();
  end
endmodule

`default_nettype wire
